/* rtl/tmr2_params.svh */
`ifndef TMR2_PARAMS_SVH
`define TMR2_PARAMS_SVH
// Register byte addresses (printed SFR offsets are multiples of four)
`define TMR2_ADDR_CTRL     12'h0C8
`define TMR2_ADDR_MODE     12'h0CC
`define TMR2_ADDR_CNT_LO   12'h0D0
`define TMR2_ADDR_CNT_HI   12'h0D4
`define TMR2_ADDR_RLD_LO   12'h0D8
`define TMR2_ADDR_RLD_HI   12'h0DC
// Control register fields
`define TMR2_CTRL_OVF      7
`define TMR2_CTRL_EXTF     6
`define TMR2_CTRL_RCLK     5
`define TMR2_CTRL_SERIAL_TX_CLOCK_SELECT     4
`define TMR2_CTRL_EXEN     3
`define TMR2_CTRL_RUN      2
`define TMR2_CTRL_CT       1
`define TMR2_CTRL_CPRL     0
// Mode register fields
`define TMR2_MODE_OE       1
`define TMR2_MODE_DOWN_COUNT_ENABLE     0
`define TMR2_CTRL_RESET    8'h00
`define TMR2_MODE_RESET    2'h0
`define TMR2_CNT_MAX       16'hFFFF
// Prescale divisors from the oscillator clock
`define TMR2_DIV_TIMER     4'hC
`define TMR2_DIV_CLKOUT    4'h2
`define TMR2_ONE           4'h1
`endif

/* rtl/tmr2_pkg.sv */
package tmr2_pkg;
   typedef enum logic [3:0] {
      TMR2_CAPTURE   = 4'h1,
      TMR2_RELOAD    = 4'h2,
      TMR2_UPDOWN    = 4'h4,
      TMR2_BAUD      = 4'h8
   } tmr2_mode_t;
   typedef logic [15:0] tmr2_word_t;
endpackage

/* rtl/tmr2_pin_if.sv */
`timescale 1ns/10ps
interface tmr2_pin_if;
   logic level;
   logic fall;
   modport sync_side (output level, output fall);
   modport user_side (input level, input fall);
endinterface

/* rtl/tmr2_pin_sync.sv */
`timescale 1ns/10ps
module tmr2_pin_sync (
   input  wire logic    clk,
   input  wire logic    rst_b,
   input  wire logic    pin,
   tmr2_pin_if.sync_side sync
);
   logic meta;
   logic stage;
   logic prev;
   // First stage feeds only the second
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta  <= 1'b1;
         stage <= 1'b1;
         prev  <= 1'b1;
      end else begin
         meta  <= pin;
         stage <= meta;
         prev  <= stage;
      end
   end
   assign sync.level = stage;
   assign sync.fall  = prev & ~stage;
endmodule // tmr2_pin_sync

/* rtl/tmr2_prescale.sv */
`timescale 1ns/10ps
`include "tmr2_params.svh"
module tmr2_prescale (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic [3:0] divisor,
   output logic            tick
);
   logic [3:0] cnt;
   wire        wrap = (cnt >= divisor - `TMR2_ONE);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt  <= 4'h0;
         tick <= 1'b0;
      end else begin
         cnt  <= wrap ? 4'h0 : cnt + `TMR2_ONE;
         tick <= wrap;
      end
   end
endmodule // tmr2_prescale

/* rtl/tmr2_top.sv */
// What this block does
// - Count is two cascaded bytes; low byte carries into high byte.
// - Input is oscillator/12 when select clear (oscillator/2 in baud or clock-out use), else external count pin.
// - Count advances only while run control is set.
// - Capture, auto-reload and baud modes chosen by clock and capture bits.
// - Down-count enable clear gives classic reload, set gives up/down.
// - Up/down: direction pin high counts up, low counts down.
// - Up overflow from FFFF sets flag, interrupts, loads reload pair.
// - Down: count equal to reload is underflow; set flag, load FFFF.
// - Up/down: external flag toggles on each wrap, no interrupt.
// - Clock-out mode counts at oscillator/2 from loaded value to overflow.
// - Clock-out overflow reloads from pair and never interrupts.
// - Clock output toggles each overflow, giving 50% duty.
// - Clock output drives the shared count pin when enabled.
// - Baud generation and clock output may run together on one pair.
// - Overflow flag set only with both serial selects clear; software clears.
// - With external enable, outside up/down and baud use, direction pin fall captures or reloads, sets flag.
// - Serial clock selects force auto-reload, ignoring capture select.
// - Counter operation increments on count pin falling edges.
// - Serial clock selects route overflow pulses to the serial port.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`include "tmr2_params.svh"
module tmr2_top (
   input  wire logic        SYS_CLK,
   input  wire logic        RST_B,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        COUNT_PIN_IN,
   output logic             COUNT_PIN_OUT,
   output logic             COUNT_PIN_OE,
   input  wire logic        DIRECTION_TRIGGER_PIN,
   output logic             TIMER_IRQ,
   output logic             SERIAL_RX_CLOCK,
   output logic             SERIAL_TX_CLOCK
);
   logic [7:0]           timer_two_control;
   logic [1:0]           timer_two_mode;
   logic [7:0]           count_low_byte;
   logic [7:0]           count_high_byte;
   logic [7:0]           reload_low_byte;
   logic [7:0]           reload_high_byte;
   logic                 clock_out;
   logic                 access_done;
   logic                 tick_osc;
   tmr2_pkg::tmr2_mode_t mode;

   tmr2_pin_if cnt_pin ();
   tmr2_pin_if dir_pin ();

   // Pins are sampled twice before any edge is taken from them
   tmr2_pin_sync u_cnt_sync (
      .clk   (SYS_CLK),
      .rst_b (RST_B),
      .pin   (COUNT_PIN_IN),
      .sync  (cnt_pin.sync_side)
   );
   tmr2_pin_sync u_dir_sync (
      .clk   (SYS_CLK),
      .rst_b (RST_B),
      .pin   (DIRECTION_TRIGGER_PIN),
      .sync  (dir_pin.sync_side)
   );

   // Control fields
   wire external_flag          = timer_two_control[`TMR2_CTRL_EXTF];
   wire serial_rx_clock_select = timer_two_control[`TMR2_CTRL_RCLK];
   wire serial_tx_clock_select = timer_two_control[`TMR2_CTRL_SERIAL_TX_CLOCK_SELECT];
   wire external_enable        = timer_two_control[`TMR2_CTRL_EXEN];
   wire run_control            = timer_two_control[`TMR2_CTRL_RUN];
   wire timer_counter_select   = timer_two_control[`TMR2_CTRL_CT];
   wire capture_reload_select  = timer_two_control[`TMR2_CTRL_CPRL];
   wire clock_output_enable    = timer_two_mode[`TMR2_MODE_OE];
   wire down_count_enable      = timer_two_mode[`TMR2_MODE_DOWN_COUNT_ENABLE];

   wire baud_mode   = serial_rx_clock_select | serial_tx_clock_select;
   // Clock-out needs the internal source; with the select set the pin is an input
   wire clkout_mode = clock_output_enable & ~timer_counter_select;

   // Mode selection; baud beats capture select
   always_comb begin
      case ({baud_mode, capture_reload_select, down_count_enable})
         3'b100:  mode = tmr2_pkg::TMR2_BAUD;
         3'b101:  mode = tmr2_pkg::TMR2_BAUD;
         3'b110:  mode = tmr2_pkg::TMR2_BAUD;
         3'b111:  mode = tmr2_pkg::TMR2_BAUD;
         3'b010:  mode = tmr2_pkg::TMR2_CAPTURE;
         3'b011:  mode = tmr2_pkg::TMR2_CAPTURE;
         3'b001:  mode = tmr2_pkg::TMR2_UPDOWN;
         default: mode = tmr2_pkg::TMR2_RELOAD;
      endcase
   end

   // One-hot taps of the mode
   wire mode_capture = (mode == tmr2_pkg::TMR2_CAPTURE);
   wire mode_reload  = (mode == tmr2_pkg::TMR2_RELOAD);
   wire mode_updown  = (mode == tmr2_pkg::TMR2_UPDOWN);

   // Prescaler: /2 for clock-out and baud, /12 for timer operation
   wire [3:0] divisor = (clkout_mode | baud_mode) ? `TMR2_DIV_CLKOUT : `TMR2_DIV_TIMER;
   tmr2_prescale u_presc (
      .clk     (SYS_CLK),
      .rst_b   (RST_B),
      .divisor (divisor),
      .tick    (tick_osc)
   );

   // A pin fall reaches the counter three clocks late, after the synchroniser
   wire in_pulse = timer_counter_select ? cnt_pin.fall : tick_osc;
   wire advance  = run_control & in_pulse;

   // Sixteen-bit views of the byte pairs
   wire [15:0] count  = {count_high_byte, count_low_byte};
   wire [15:0] reload = {reload_high_byte, reload_low_byte};
   wire        updown = mode_updown & ~clkout_mode;
   wire        go_up  = ~updown | dir_pin.level;

   // Underflow compares against the reload pair, not against zero
   wire at_top      = (count == `TMR2_CNT_MAX);
   wire up_ovf      = advance & go_up & at_top;
   wire down_unf    = advance & ~go_up & (count == reload);
   wire wrap        = up_ovf | down_unf;
   wire [15:0] next_count_up   = count + 16'h0001;
   wire [15:0] next_count_down = count - 16'h0001;

   // External trigger, not in up/down or serial clock use
   wire ext_event   = external_enable & dir_pin.fall & ~updown & ~baud_mode;
   wire do_capture  = ext_event & mode_capture;
   wire ext_reload  = ext_event & mode_reload;

   // Overflow flag only with both serial selects clear
   wire ovf_set  = wrap & ~baud_mode & ~clkout_mode;
   wire extf_tog = wrap & updown;

   // APB decode; ready comes one cycle into the access phase, one wait state
   wire apb_access = PSEL & PENABLE & ~access_done;
   wire apb_wr     = PSEL & PENABLE & PREADY & PWRITE; // Lands at the completing edge
   wire hit_ctrl   = (PADDR == `TMR2_ADDR_CTRL);
   wire hit_mode   = (PADDR == `TMR2_ADDR_MODE);
   wire hit_cnt_lo = (PADDR == `TMR2_ADDR_CNT_LO);
   wire hit_cnt_hi = (PADDR == `TMR2_ADDR_CNT_HI);
   wire hit_rld_lo = (PADDR == `TMR2_ADDR_RLD_LO);
   wire hit_rld_hi = (PADDR == `TMR2_ADDR_RLD_HI);
   wire hit_any    = hit_ctrl | hit_mode | hit_cnt_lo | hit_cnt_hi | hit_rld_lo | hit_rld_hi;
   wire wr_ctrl    = apb_wr & hit_ctrl;
   wire wr_mode    = apb_wr & hit_mode;
   wire wr_cnt_lo  = apb_wr & hit_cnt_lo;
   wire wr_cnt_hi  = apb_wr & hit_cnt_hi;
   wire wr_rld_lo  = apb_wr & hit_rld_lo;
   wire wr_rld_hi  = apb_wr & hit_rld_hi;

   wire [7:0]  wdata       = PWDATA[7:0];
   // Read words; unused upper bits read as zero
   wire [31:0] word_ctrl   = {24'h000000, timer_two_control};
   wire [31:0] word_mode   = {24'h000000, 6'h00, timer_two_mode};
   wire [31:0] word_cnt_lo = {24'h000000, count_low_byte};
   wire [31:0] word_cnt_hi = {24'h000000, count_high_byte};
   wire [31:0] word_rld_lo = {24'h000000, reload_low_byte};
   wire [31:0] word_rld_hi = {24'h000000, reload_high_byte};
   wire [31:0] rdata_mux =
      hit_ctrl   ? word_ctrl :
      hit_mode   ? word_mode :
      hit_cnt_lo ? word_cnt_lo :
      hit_cnt_hi ? word_cnt_hi :
      hit_rld_lo ? word_rld_lo :
      hit_rld_hi ? word_rld_hi : 32'h00000000;

   // Control: hardware set/toggle wins over a software write in the same cycle
   wire [7:0] ctrl_sw = wr_ctrl ? wdata : timer_two_control;
   wire next_ovf  = ovf_set | ctrl_sw[`TMR2_CTRL_OVF];
   wire next_extf = extf_tog ? ~external_flag :
                    (ext_event | ctrl_sw[`TMR2_CTRL_EXTF]);
   wire [7:0] next_ctrl = {next_ovf, next_extf, ctrl_sw[5:0]};

   // Count next value; software write wins over counting
   wire [15:0] next_count_hw =
      up_ovf   ? reload :
      down_unf ? `TMR2_CNT_MAX :
      ext_reload ? reload :
      advance  ? (go_up ? next_count_up : next_count_down) : count;
   wire [7:0] next_cnt_lo = wr_cnt_lo ? wdata : next_count_hw[7:0];
   wire [7:0] next_cnt_hi = wr_cnt_hi ? wdata : next_count_hw[15:8];

   // Capture loads the count into the reload pair
   wire [7:0] next_rld_lo = wr_rld_lo ? wdata : (do_capture ? count_low_byte : reload_low_byte);
   wire [7:0] next_rld_hi = wr_rld_hi ? wdata : (do_capture ? count_high_byte : reload_high_byte);

   // Interrupt on overflow flag, or on external flag outside up/down
   wire        next_irq         = next_ovf | (next_extf & ~updown);
   wire        next_pin_out     = clock_out;
   wire        next_pin_oe      = clkout_mode;
   wire        next_rx_clock    = up_ovf & serial_rx_clock_select;
   wire        next_tx_clock    = up_ovf & serial_tx_clock_select;

   // Mode bits above the two defined ones are not stored
   wire [1:0]  next_mode        = wr_mode ? wdata[1:0] : timer_two_mode;

   // Square wave: toggle per overflow, period 4*(65536-reload) osc cycles
   wire        next_clock_out   = clkout_mode & (up_ovf ^ clock_out);

   // One answer per access; the done bit blocks a second pulse in the cycle right after an answer
   wire        next_access_done = apb_access;
   wire        next_pready      = apb_access;
   wire        next_pslverr     = apb_access & ~hit_any;
   wire [31:0] next_prdata      = (apb_access & ~PWRITE) ? rdata_mux : 32'h00000000;

   // Software-visible registers
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         timer_two_control <= `TMR2_CTRL_RESET;
      end else begin
         timer_two_control <= next_ctrl;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         timer_two_mode <= `TMR2_MODE_RESET;
      end else begin
         timer_two_mode <= next_mode;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         count_low_byte <= 8'h00;
      end else begin
         count_low_byte <= next_cnt_lo;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         count_high_byte <= 8'h00;
      end else begin
         count_high_byte <= next_cnt_hi;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         reload_low_byte <= 8'h00;
      end else begin
         reload_low_byte <= next_rld_lo;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         reload_high_byte <= 8'h00;
      end else begin
         reload_high_byte <= next_rld_hi;
      end
   end

   // Clock-out level and pin outputs, all straight from flip-flops
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         clock_out <= 1'b0;
      end else begin
         clock_out <= next_clock_out;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         COUNT_PIN_OUT <= 1'b0;
      end else begin
         COUNT_PIN_OUT <= next_pin_out;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         COUNT_PIN_OE <= 1'b0;
      end else begin
         COUNT_PIN_OE <= next_pin_oe;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         TIMER_IRQ <= 1'b0;
      end else begin
         TIMER_IRQ <= next_irq;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         SERIAL_RX_CLOCK <= 1'b0;
      end else begin
         SERIAL_RX_CLOCK <= next_rx_clock;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         SERIAL_TX_CLOCK <= 1'b0;
      end else begin
         SERIAL_TX_CLOCK <= next_tx_clock;
      end
   end

   // APB answer: one access cycle, error on unmapped address
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         access_done <= 1'b0;
      end else begin
         access_done <= next_access_done;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         PREADY <= 1'b0;
      end else begin
         PREADY <= next_pready;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         PSLVERR <= 1'b0;
      end else begin
         PSLVERR <= next_pslverr;
      end
   end

   // Read data is registered with the answer, so it stands only while ready is high
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         PRDATA <= 32'h00000000;
      end else begin
         PRDATA <= next_prdata;
      end
   end
endmodule // tmr2_top

/* tb/tmr2_sva.sv */
`timescale 1ns/10ps
module tmr2_sva (
   input wire logic        SYS_CLK,
   input wire logic        RST_B,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        COUNT_PIN_IN,
   input wire logic        COUNT_PIN_OUT,
   input wire logic        COUNT_PIN_OE,
   input wire logic        DIRECTION_TRIGGER_PIN,
   input wire logic        TIMER_IRQ,
   input wire logic        SERIAL_RX_CLOCK,
   input wire logic        SERIAL_TX_CLOCK
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   wire wr_req = PSEL & PWRITE;
   chk_ready_next: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("access phase not answered next cycle");
   chk_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready held past one cycle");
   chk_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
      else $error("read data outside answer");
   chk_err_ready: assert property (PSLVERR |-> PREADY && PSEL)
      else $error("error without answer");
   chk_clk_half: assert property ($changed(COUNT_PIN_OUT) |=> $stable(COUNT_PIN_OUT))
      else $error("clock out half period below two cycles");
   chk_tx_pulse: assert property (SERIAL_TX_CLOCK |=> !SERIAL_TX_CLOCK)
      else $error("transmit clock pulse too long");
   chk_rx_pulse: assert property (SERIAL_RX_CLOCK |=> !SERIAL_RX_CLOCK)
      else $error("receive clock pulse too long");
   chk_irq_clear: assert property ($fell(TIMER_IRQ) |->
      $past(wr_req) || $past(wr_req, 2))
      else $error("interrupt dropped without software write");
   chk_oe_write: assert property ($changed(COUNT_PIN_OE) |->
      $past(wr_req) || $past(wr_req, 2))
      else $error("pin drive changed without write");
   cover property (PSLVERR);
   cover property ($rose(COUNT_PIN_OUT));
   cover property ($rose(TIMER_IRQ));
endmodule // tmr2_sva
bind tmr2_top tmr2_sva u_sva (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .COUNT_PIN_IN(COUNT_PIN_IN),
   .COUNT_PIN_OUT(COUNT_PIN_OUT), .COUNT_PIN_OE(COUNT_PIN_OE),
   .DIRECTION_TRIGGER_PIN(DIRECTION_TRIGGER_PIN), .TIMER_IRQ(TIMER_IRQ),
   .SERIAL_RX_CLOCK(SERIAL_RX_CLOCK), .SERIAL_TX_CLOCK(SERIAL_TX_CLOCK));

/* tb/tmr2_pin_model.sv */
`timescale 1ns/10ps
module tmr2_pin_model (
   input  wire logic clk,
   input  wire logic pin_oe,
   input  wire logic pin_out,
   output logic      count_pin,
   output logic      dir_pin
);
   logic ext = 1'b1;
   logic dir = 1'b1;
   // Shared pin: device level wins while it drives
   assign count_pin = pin_oe ? pin_out : ext;
   assign dir_pin   = dir;
   // Low and high phases longer than the synchroniser depth
   task automatic pulse;
      @(posedge clk) ext <= 1'b0;
      repeat (4) @(posedge clk);
      ext <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   task automatic set_dir(input logic v);
      @(posedge clk) dir <= v;
      repeat (6) @(posedge clk);
   endtask
endmodule // tmr2_pin_model

/* tb/tmr2_top_tb.sv */
`timescale 1ns/10ps
`include "tmr2_params.svh"
module tmr2_top_tb;
   logic        sys_clk = 1'b0;
   logic        rst_b   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata, rdat;
   logic        pready, pslverr, pin_out, pin_oe, count_pin, dir_pin, irq, rx_clk, tx_clk;
   logic        rerr;
   logic [7:0]  held;
   int          error_cnt = 0;
   int          samples_checked = 0;
   int          n, k;
   tmr2_top dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .COUNT_PIN_IN(count_pin), .COUNT_PIN_OUT(pin_out),
      .COUNT_PIN_OE(pin_oe), .DIRECTION_TRIGGER_PIN(dir_pin), .TIMER_IRQ(irq),
      .SERIAL_RX_CLOCK(rx_clk), .SERIAL_TX_CLOCK(tx_clk));
   tmr2_pin_model pm (.clk(sys_clk), .pin_oe(pin_oe), .pin_out(pin_out),
      .count_pin(count_pin), .dir_pin(dir_pin));
   initial forever #10 sys_clk = ~sys_clk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= {24'h000000, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      // Waits for the answer however long it takes; only the watchdog ends a hang
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rc(input logic [11:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk({8'h00, rdat[7:0]}, {8'h00, exp});
   endtask
   task automatic w16(input logic [11:0] a, input logic [15:0] v);
      apb(1'b1, a, v[7:0]);
      apb(1'b1, a + 12'h004, v[15:8]);
   endtask
   task automatic gap(output int g);
      logic v;
      v = pin_out;
      g = 0;
      do begin
         @(posedge sys_clk);
         g++;
      end while (pin_out === v && g < 100);
   endtask
   task automatic summarize;
      $display("errors %0d, checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #200000;
      error_cnt++;
      $display("Error at %0t: watchdog expired", $time);
      summarize;
   end
   initial begin
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      rc(`TMR2_ADDR_CTRL, 8'h00);
      rc(`TMR2_ADDR_MODE, 8'h00);
      apb(1'b0, 12'h0E0, 8'h00);
      chk({rerr, rdat[14:0]}, 16'h8000);
      w16(`TMR2_ADDR_RLD_LO, 16'h1234);
      w16(`TMR2_ADDR_CNT_LO, 16'hFFF0);
      rc(`TMR2_ADDR_CNT_HI, 8'hFF);
      apb(1'b1, `TMR2_ADDR_CTRL, 8'h04);
      repeat (300) @(posedge sys_clk);
      rc(`TMR2_ADDR_CTRL, 8'h84);
      rc(`TMR2_ADDR_CNT_HI, 8'h12);
      chk({15'h0000, irq}, 16'h0001);
      apb(1'b1, `TMR2_ADDR_CTRL, 8'h00);
      apb(1'b0, `TMR2_ADDR_CNT_LO, 8'h00);
      held = rdat[7:0];
      repeat (30) @(posedge sys_clk);
      rc(`TMR2_ADDR_CNT_LO, held);
      chk({15'h0000, irq}, 16'h0000);
      w16(`TMR2_ADDR_CNT_LO, 16'h00FF);
      apb(1'b1, `TMR2_ADDR_CTRL, 8'h04);
      repeat (30) @(posedge sys_clk);
      apb(1'b1, `TMR2_ADDR_CTRL, 8'h00);
      rc(`TMR2_ADDR_CNT_HI, 8'h01);
      w16(`TMR2_ADDR_CNT_LO, 16'h5500);
      apb(1'b1, `TMR2_ADDR_CTRL, 8'h0D);
      pm.set_dir(1'b0);
      pm.set_dir(1'b1);
      rc(`TMR2_ADDR_RLD_HI, 8'h55);
      rc(`TMR2_ADDR_CTRL, 8'h4D);
      chk({15'h0000, irq}, 16'h0001);
      w16(`TMR2_ADDR_CNT_LO, 16'h0000);
      apb(1'b1, `TMR2_ADDR_CTRL, 8'h08);
      pm.set_dir(1'b0);
      pm.set_dir(1'b1);
      rc(`TMR2_ADDR_CNT_HI, 8'h55);
      rc(`TMR2_ADDR_CTRL, 8'h48);
      apb(1'b1, `TMR2_ADDR_CTRL, 8'h00);
      apb(1'b1, `TMR2_ADDR_MODE, 8'h01);
      w16(`TMR2_ADDR_RLD_LO, 16'h1000);
      w16(`TMR2_ADDR_CNT_LO, 16'h1002);
      pm.set_dir(1'b0);
      apb(1'b1, `TMR2_ADDR_CTRL, 8'h04);
      repeat (100) @(posedge sys_clk);
      rc(`TMR2_ADDR_CTRL, 8'hC4);
      rc(`TMR2_ADDR_CNT_HI, 8'hFF);
      apb(1'b1, `TMR2_ADDR_CTRL, 8'h40);
      repeat (3) @(posedge sys_clk);
      chk({15'h0000, irq}, 16'h0000);
      pm.set_dir(1'b1);
      w16(`TMR2_ADDR_CNT_LO, 16'hFFFE);
      apb(1'b1, `TMR2_ADDR_CTRL, 8'h44);
      repeat (100) @(posedge sys_clk);
      rc(`TMR2_ADDR_CTRL, 8'h84);
      rc(`TMR2_ADDR_CNT_HI, 8'h10);
      apb(1'b1, `TMR2_ADDR_CTRL, 8'h00);
      apb(1'b1, `TMR2_ADDR_MODE, 8'h00);
      w16(`TMR2_ADDR_CNT_LO, 16'h0000);
      apb(1'b1, `TMR2_ADDR_CTRL, 8'h06);
      repeat (3) pm.pulse;
      rc(`TMR2_ADDR_CNT_LO, 8'h03);
      chk({15'h0000, pin_oe}, 16'h0000);
      // Set-up order that software must keep for clock output
      apb(1'b1, `TMR2_ADDR_MODE, 8'h02);
      apb(1'b1, `TMR2_ADDR_CTRL, 8'h00);
      w16(`TMR2_ADDR_RLD_LO, 16'hFFFE);
      w16(`TMR2_ADDR_CNT_LO, 16'hFFFE);
      apb(1'b1, `TMR2_ADDR_CTRL, 8'h04);
      chk({15'h0000, pin_oe}, 16'h0001);
      gap(n);
      gap(n);
      gap(k);
      chk(n[15:0] + k[15:0], 16'h0008);
      chk(n[15:0], 16'h0004);
      rc(`TMR2_ADDR_CTRL, 8'h04);
      chk({15'h0000, irq}, 16'h0000);
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, `TMR2_ADDR_CTRL, i ? 8'h24 : 8'h14);
         k = 0;
         repeat (40) @(posedge sys_clk) k += ((i ? rx_clk : tx_clk) === 1'b1);
         chk({15'h0000, k >= 9 && k <= 11}, 16'h0001);
         rc(`TMR2_ADDR_CTRL, i ? 8'h24 : 8'h14);
         gap(n);
         gap(n);
         chk(n[15:0], 16'h0004);
      end
      summarize;
   end
endmodule // tmr2_top_tb
